// File: bench/i2cs_master_model.sv
// Behavioural two-wire bus master on open-drain lines.
// Assumes pull-ups resolve the wires in the bench; bit timing by delays.
module i2cs_master_model (
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_scl_oe_n,
   output logic o_sda_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // Half period, five link periods
   localparam int T = 800;
   initial begin
      o_scl_oe_n = 1'b1;
      o_sda_oe_n = 1'b1;
   end
   task automatic start();
      o_sda_oe_n = 1'b1;
      #(T);
      o_scl_oe_n = 1'b1;
      wait (i_scl === 1'b1);
      #(T);
      o_sda_oe_n = 1'b0;
      #(T);
      o_scl_oe_n = 1'b0;
      #(T / 2);
   endtask : start
   // Nine bits MSB first; a 1 in drv leaves the data line to the slave
   task automatic xfer(input logic [8:0] drv, output logic [8:0] got);
      for (int i = 8; i >= 0; i--) begin
         o_sda_oe_n = drv[i];
         #(T);
         o_scl_oe_n = 1'b1;
         // Waits out any stretch by the slave
         wait (i_scl === 1'b1);
         #(T);
         got[i] = i_sda;
         o_scl_oe_n = 1'b0;
         #(T / 2);
      end
   endtask : xfer
   task automatic stop();
      o_sda_oe_n = 1'b0;
      #(T);
      o_scl_oe_n = 1'b1;
      wait (i_scl === 1'b1);
      #(T);
      o_sda_oe_n = 1'b1;
      #(T);
   endtask : stop
endmodule : i2cs_master_model

// File: bench/i2cs_props.sv
// Concurrent checks on the two-wire slave ports, bound into every slave instance.
// Assumes i_nrst resets both clock domains and the bus wires have pull-ups.
module i2cs_props import i2cs_pkg::*; (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_link_clk,
   input wire logic i_scl,
   input wire i2cs_sw_t i_sw,
   input wire logic o_scl_oe_n,
   input wire logic o_sda_oe_n,
   input wire i2cs_stat_t o_stat,
   input wire logic [7:0] o_buf_data,
   input wire logic [7:0] o_slave_addr
);
   timeunit 1ns;
   timeprecision 100ps;
   property p_hold_after_low;
      @(posedge i_link_clk) disable iff (!i_nrst) $fell(o_scl_oe_n) |-> !$past(i_scl);
   endproperty
   a_hold_after_low: assert property (p_hold_after_low)
      else $error("clock pulled low while it was high");
   property p_sda_drive_in_low;
      @(posedge i_link_clk) disable iff (!i_nrst) $fell(o_sda_oe_n) |-> !i_scl;
   endproperty
   a_sda_drive_in_low: assert property (p_sda_drive_in_low)
      else $error("data line driven while clock high");
   property p_sda_free_in_low;
      @(posedge i_link_clk) disable iff (!i_nrst) $rose(o_sda_oe_n) |-> !i_scl;
   endproperty
   a_sda_free_in_low: assert property (p_sda_free_in_low)
      else $error("data line released while clock high");
   property p_buf_load;
      @(posedge i_sys_clk) disable iff (!i_nrst)
         i_sw.buf_write |=> o_buf_data == $past(i_sw.wdata) && o_stat.buffer_full_flag;
   endproperty
   a_buf_load: assert property (p_buf_load)
      else $error("buffer write not taken");
   property p_addr_load;
      @(posedge i_sys_clk) disable iff (!i_nrst)
         i_sw.addr_write |=> o_slave_addr == $past(i_sw.wdata);
   endproperty
   a_addr_load: assert property (p_addr_load)
      else $error("address write not taken");
   property p_irq_stands;
      @(posedge i_sys_clk) disable iff (!i_nrst)
         o_stat.port_irq_flag && !i_sw.irq_clear |=> o_stat.port_irq_flag;
   endproperty
   a_irq_stands: assert property (p_irq_stands)
      else $error("port flag dropped without clear");
   property p_coll_stands;
      @(posedge i_sys_clk) disable iff (!i_nrst)
         o_stat.bus_collision_flag && !i_sw.bcl_clear |=> o_stat.bus_collision_flag;
   endproperty
   a_coll_stands: assert property (p_coll_stands)
      else $error("collision flag dropped without clear");
   property p_release;
      @(posedge i_sys_clk) disable iff (!i_nrst)
         $rose(o_stat.link.clock_release_bit) && !o_stat.link.update_address_flag
         |-> ##[0:8] o_scl_oe_n;
   endproperty
   a_release: assert property (p_release)
      else $error("clock not released after release bit set");
endmodule : i2cs_props

bind i2cs_slave i2cs_props u_props (
   .i_sys_clk, .i_nrst, .i_link_clk, .i_scl, .i_sw,
   .o_scl_oe_n, .o_sda_oe_n, .o_stat, .o_buf_data, .o_slave_addr
);

// File: bench/i2cs_slave_bench.sv
// Bench for the two-wire slave: read, hold, write, 10-bit and collision runs.
// Assumes the master model and the bound checker are compiled beside it.
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
   $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end

module i2cs_slave_bench import i2cs_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [5:0] WBUF = 6'h20, RBUF = 6'h10, WADR = 6'h08;
   localparam logic [5:0] REL = 6'h04, CLRI = 6'h02, CLRC = 6'h01;
   logic sys_clk, link_clk, nrst;
   logic m_scl_oe_n, m_sda_oe_n, d_scl_oe_n, d_sda_oe_n, d_scl_out, d_sda_out;
   i2cs_cfg_t cfg;
   i2cs_sw_t sw;
   i2cs_stat_t stat;
   logic [7:0] buf_data, slave_addr;
   logic [8:0] got;
   wire i2cs_link_stat_t ls = stat.link;
   int bad_count = 0, n_compared = 0, cycles = 0;
   // Open-drain wires with pull-ups
   wire logic scl = m_scl_oe_n & (d_scl_oe_n | d_scl_out);
   wire logic sda = m_sda_oe_n & (d_sda_oe_n | d_sda_out);

   i2cs_slave u_dut (
      .i_sys_clk(sys_clk), .i_nrst(nrst), .i_link_clk(link_clk), .i_scl(scl),
      .i_sda(sda), .i_cfg(cfg), .i_sw(sw), .o_scl_out(d_scl_out),
      .o_scl_oe_n(d_scl_oe_n), .o_sda_out(d_sda_out), .o_sda_oe_n(d_sda_oe_n),
      .o_stat(stat), .o_buf_data(buf_data), .o_slave_addr(slave_addr)
   );
   i2cs_master_model u_mst (
      .i_scl(scl), .i_sda(sda), .o_scl_oe_n(m_scl_oe_n), .o_sda_oe_n(m_sda_oe_n)
   );

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #80 link_clk = ~link_clk;
   end

   task automatic conclude();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   task automatic sw_op(input logic [5:0] s, input logic [7:0] d);
      @(posedge sys_clk);
      sw <= {s, d};
      @(posedge sys_clk);
      sw <= '0;
      @(negedge sys_clk);
   endtask : sw_op

   task automatic wait_irq();
      int n;
      n = 0;
      while (stat.port_irq_flag !== 1'b1 && n < 3000) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 3000) begin
         bad_count++;
      end
      repeat (4) @(negedge sys_clk);
   endtask : wait_irq

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         conclude();
      end
   end

   initial begin
      nrst = 1'b0;
      cfg = '0;
      sw = '0;
      repeat (5) @(posedge link_clk);
      @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (6) @(posedge link_clk);
      sw_op(WADR, 8'ha4);
      `CHK(slave_addr, 8'ha4)
      // Read with start flag: cfg fields slave_collision_detect_enable address_hold_enable data_hold_enable sen ten sirq ackv
      cfg <= 7'h02;
      fork
         begin
            u_mst.start();
            u_mst.xfer(9'h14b, got);
            `CHK(got[0], 1'b0)
            u_mst.xfer(9'h1fe, got);
            `CHK(got[8:1], 8'h96)
            u_mst.xfer(9'h1ff, got);
            `CHK(got[8:1], 8'h3c)
            u_mst.xfer(9'h1ff, got);
            `CHK(got[8:1], 8'hff)
            u_mst.stop();
         end
         begin
            wait_irq();
            `CHK(stat.link.start_seen, 1'b1)
            sw_op(CLRI, 8'h00);
            wait_irq();
            `CHK({buf_data, ls.read_write, ls.clock_release_bit, d_scl_oe_n}, 11'h52c)
            sw_op(CLRI | RBUF, 8'h00);
            sw_op(WBUF, 8'h96);
            `CHK({buf_data, stat.buffer_full_flag}, 9'h12d)
            sw_op(REL, 8'h00);
            wait_irq();
            `CHK({stat.link.received_ack_status, stat.link.clock_release_bit}, 2'h0)
            sw_op(CLRI | WBUF | REL, 8'h3c);
            wait_irq();
            `CHK({stat.link.received_ack_status, d_scl_oe_n}, 2'h3)
            sw_op(CLRI, 8'h00);
         end
      join
      `CHK(stat.link.stop_seen, 1'b1)
      $display("read test done");
      cfg <= 7'h40;
      fork
         begin
            u_mst.start();
            u_mst.xfer(9'h14b, got);
            u_mst.xfer(9'h0ff, got);
            `CHK(got[8:1], 8'h7f)
            u_mst.stop();
         end
         begin
            wait_irq();
            sw_op(CLRI | RBUF | WBUF | REL, 8'hff);
         end
      join
      `CHK(stat.bus_collision_flag, 1'b1)
      sw_op(CLRC | CLRI, 8'h00);
      `CHK(stat.bus_collision_flag, 1'b0)
      $display("collision test done");
      cfg <= 7'h21;
      fork
         begin
            u_mst.start();
            u_mst.xfer(9'h14b, got);
            `CHK(got[0], 1'b1)
            u_mst.stop();
         end
         begin
            wait_irq();
            `CHK({ls.clock_release_bit, ls.ack_time_flag, d_scl_oe_n}, 3'h2)
            `CHK({ls.data_not_addr, ls.read_write}, 2'h1)
            sw_op(CLRI | RBUF | REL, 8'h00);
         end
      join
      `CHK(stat.port_irq_flag, 1'b0)
      $display("address hold test done");
      cfg <= 7'h18;
      fork
         begin
            u_mst.start();
            u_mst.xfer(9'h149, got);
            u_mst.xfer(9'h0b5, got);
            `CHK(got[0], 1'b0)
            u_mst.stop();
         end
         begin
            wait_irq();
            sw_op(CLRI | RBUF | REL, 8'h00);
            wait_irq();
            `CHK({ls.clock_release_bit, ls.ack_time_flag, ls.data_not_addr}, 3'h3)
            sw_op(CLRI | REL, 8'h00);
            wait_irq();
            `CHK({buf_data, stat.link.clock_release_bit, stat.link.ack_time_flag}, 10'h168)
            sw_op(CLRI | RBUF | REL, 8'h00);
         end
      join
      $display("data hold test done");
      cfg <= 7'h04;
      sw_op(WADR, 8'hf4);
      fork
         begin
            u_mst.start();
            u_mst.xfer(9'h1ed, got);
            `CHK(got[0], 1'b1)
            u_mst.stop();
            u_mst.start();
            u_mst.xfer(9'h1e9, got);
            `CHK(got[0], 1'b0)
            u_mst.xfer(9'h079, got);
            `CHK(got[0], 1'b1)
            u_mst.stop();
         end
         begin
            wait_irq();
            `CHK({ls.update_address_flag, ls.clock_release_bit, d_scl_oe_n}, 3'h6)
            sw_op(CLRI | RBUF | WADR, 8'hc5);
            repeat (20) @(negedge sys_clk);
            `CHK(d_scl_oe_n, 1'b1)
            wait_irq();
            `CHK({ls.update_address_flag, ls.clock_release_bit}, 2'h3)
            `CHK(stat.buffer_full_flag, 1'b0)
            sw_op(CLRI | WADR, 8'hf4);
         end
      join
      $display("ten bit test done");
      conclude();
   end
endmodule : i2cs_slave_bench

// File: hw/i2cs_defs.svh
// Constants of the two-wire slave: reset values, address pattern, bit counts.
// Assumes inclusion by bare name from the package and the slave module.
`ifndef I2CS_DEFS_SVH
`define I2CS_DEFS_SVH

// Fixed top five bits of a 10-bit high address byte
`define I2CS_TEN_PREFIX 5'h1e
// Bit count at which a byte is complete
`define I2CS_LAST_BIT 4'h8
`define I2CS_CNT_RST 4'h0
`define I2CS_BYTE_RST 8'h00
`define I2CS_CKP_RST 1'b1
// Bus lines idle high
`define I2CS_PIN_RST 2'h3
`define I2CS_TGL_RST 3'h0

`endif

// File: hw/i2cs_pkg.sv
// Types shared by the two-wire slave and its bench.
// Assumes the constants header sits beside it.
`include "i2cs_defs.svh"

package i2cs_pkg;

   typedef enum logic [2:0] {
      S_IDLE,
      S_RX,
      S_RACK,
      S_TX,
      S_TACK
   } i2cs_state_t;

   // Quasi-static configuration levels from software
   typedef struct packed {
      logic slave_collision_detect_enable;
      logic address_hold_enable;
      logic data_hold_enable;
      logic stretch_enable;
      logic ten_bit_mode;
      logic start_irq_enable;
      logic ack_value_bit;
   } i2cs_cfg_t;

   // One-cycle software strobes; wdata goes with buf_write and addr_write
   typedef struct packed {
      logic buf_write;
      logic buf_read;
      logic addr_write;
      logic ckp_set;
      logic irq_clear;
      logic bcl_clear;
      logic [7:0] wdata;
   } i2cs_sw_t;

   // Status kept at the link side
   typedef struct packed {
      logic clock_release_bit;
      logic received_ack_status;
      logic ack_time_flag;
      logic read_write;
      logic data_not_addr;
      logic update_address_flag;
      logic start_seen;
      logic stop_seen;
   } i2cs_link_stat_t;

   typedef struct packed {
      logic port_irq_flag;
      logic bus_collision_flag;
      logic buffer_full_flag;
      i2cs_link_stat_t link;
   } i2cs_stat_t;

endpackage : i2cs_pkg

// File: hw/i2cs_slave.sv
// Two-wire bus slave: 7/10-bit address, transmit, clock stretching, hold points.
// Assumes open-drain pins resolved outside; i_link_clk oversamples the bus lines.
//
// Notes on behaviour
// RQ1 - Collision while sending, when enabled, sets collision flag and drops to idle.
// RQ2 - Start sets start-seen; raises port flag only if start interrupt enabled.
// RQ3 - Matched read address: load buffer, raise flag, clear clock release bit.
// RQ4 - Software loads buffer then sets release bit to let master clock byte.
// RQ5 - Transmit: raise flag after master acknowledge captured into status bit.
// RQ6 - Received acknowledge status captured on rising edge of ninth clock.
// RQ7 - Master ACK stretches again; master NACK holds nothing but raises flag.
// RQ8 - Repeated start or stop ends the addressed state.
// RQ9 - Address hold: after 8th fall clear release bit, hold clock, raise flag.
// RQ10 - Ack-time, read/write and data/address status identify hold-point cause.
// RQ11 - At hold points software's ack value is driven in acknowledge slot.
// RQ12 - Software loads buffer only after the address acknowledge completes.
// RQ13 - Master NACKs last byte so the slave releases the clock for stop.
// RQ14 - 10-bit matching high write byte: set update flag, acknowledge, raise flag.
// RQ15 - Update flag stretches clock; address register write releases it at once.
// RQ16 - Software writes address register only after acknowledge sequence ends.
// RQ17 - 10-bit low mismatch: flag and update set, buffer empty, release unchanged.
// RQ18 - Stretch enable: clear release bit after each received byte.
// RQ19 - Cleared release bit waits for clock low, then holds it low.
// RQ20 - Stretch enable always stretches after acknowledge, besides read stretch.
// RQ21 - Stretching ignores buffer-full; read requests always clear release bit.
// RQ22 - Data hold: clear release bit after 8th fall of each data byte.
// RQ23 - 10-bit high byte compared to five fixed bits, two top bits, zero.
// RQ24 - Transmit raises flag on the ninth falling clock edge.
// RQ25 - Bus lines synchronised before edge, start and stop detection.
`include "i2cs_defs.svh"

module i2cs_slave import i2cs_pkg::*; (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_link_clk,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire i2cs_cfg_t i_cfg,
   input wire i2cs_sw_t i_sw,
   output logic o_scl_out,
   output logic o_scl_oe_n,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   output i2cs_stat_t o_stat,
   output logic [7:0] o_buf_data,
   output logic [7:0] o_slave_addr
);

   function automatic logic is_hi_byte(input logic [7:0] b, input logic [7:0] a);
      is_hi_byte = (b[7:1] == {`I2CS_TEN_PREFIX, a[2:1]});
   endfunction : is_hi_byte

   // ---------------- System clock side ----------------
   logic [7:0] buf_r, buf_nxt, addr_r, addr_nxt;
   logic irq_r, irq_nxt, bcl_r, bcl_nxt, bf_r, bf_nxt;
   logic [2:0] sw_tgl_r, lk_s1_r, lk_s2_r, lk_s3_r;
   logic [2:0] lk_ev;
   i2cs_link_stat_t st_s1_r, st_s2_r;
   // Link-side registers read across the domain boundary
   logic [2:0] lk_tgl_r;
   logic [7:0] rx_hold_r;
   i2cs_link_stat_t ls_r;

   // Events from the link: bit0 port flag, bit1 collision, bit2 buffer load
   assign lk_ev = lk_s2_r ^ lk_s3_r;
   // Hardware set wins over software clear
   assign irq_nxt = lk_ev[0] | (irq_r & ~i_sw.irq_clear);
   assign bcl_nxt = lk_ev[1] | (bcl_r & ~i_sw.bcl_clear);
   assign bf_nxt = lk_ev[2] | i_sw.buf_write | (bf_r & ~i_sw.buf_read);
   assign buf_nxt = lk_ev[2] ? rx_hold_r : (i_sw.buf_write ? i_sw.wdata : buf_r);
   assign addr_nxt = i_sw.addr_write ? i_sw.wdata : addr_r;

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         buf_r <= `I2CS_BYTE_RST;
         addr_r <= `I2CS_BYTE_RST;
         irq_r <= 1'b0;
         bcl_r <= 1'b0;
         bf_r <= 1'b0;
         sw_tgl_r <= `I2CS_TGL_RST;
         lk_s1_r <= `I2CS_TGL_RST;
         lk_s2_r <= `I2CS_TGL_RST;
         lk_s3_r <= `I2CS_TGL_RST;
         st_s1_r <= '0;
         st_s2_r <= '0;
      end else begin
         buf_r <= buf_nxt;
         addr_r <= addr_nxt;
         irq_r <= irq_nxt;
         bcl_r <= bcl_nxt;
         bf_r <= bf_nxt;
         // Strobes to the link: bit0 release set, bit1 address write, bit2 buffer write
         sw_tgl_r <= sw_tgl_r ^ {i_sw.buf_write, i_sw.addr_write, i_sw.ckp_set};
         lk_s1_r <= lk_tgl_r;
         lk_s2_r <= lk_s1_r;
         lk_s3_r <= lk_s2_r;
         st_s1_r <= ls_r;
         st_s2_r <= st_s1_r;
      end
   end

   assign o_stat = {irq_r, bcl_r, bf_r, st_s2_r};
   assign o_buf_data = buf_r;
   assign o_slave_addr = addr_r;

   // ---------------- Link clock side ----------------
   i2cs_cfg_t cfg_s1_r, cfg;
   logic [2:0] sw_s1_r, sw_s2_r, sw_s3_r, sw_ev;
   logic [1:0] pin_s1_r, pin_s2_r, pin_s3_r;
   logic scl, sda, scl_rise, scl_fall, start_det, stop_det;
   i2cs_state_t state_r, state_nxt;
   i2cs_link_stat_t ls_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] shift_r, shift_nxt, txsh_r, txsh_nxt, tx_r, addr_l_r, rx_hold_nxt;
   logic first_r, first_nxt, hi_r, hi_nxt, lo_r, lo_nxt, ten_ok_r, ten_ok_nxt;
   logic hit_r, hit_nxt, swack_r, swack_nxt;
   logic sda_lo_r, sda_lo_nxt, hold_r, hold_nxt;
   logic ev_irq, ev_bcl, ev_load;
   logic addr_match, byte_done, ack_low, need_hold;

   // RQ25 two-stage sync
   assign scl = pin_s2_r[1];
   assign sda = pin_s2_r[0];
   assign scl_rise = scl & ~pin_s3_r[1];
   assign scl_fall = ~scl & pin_s3_r[1];
   assign start_det = scl & pin_s3_r[1] & pin_s3_r[0] & ~sda;
   assign stop_det = scl & pin_s3_r[1] & ~pin_s3_r[0] & sda;
   assign sw_ev = sw_s2_r ^ sw_s3_r;

   // RQ23 high byte pattern, read allowed only after full 10-bit match
   assign addr_match = cfg.ten_bit_mode ?
      (hi_r ? (shift_r == addr_l_r) : (is_hi_byte(shift_r, addr_l_r) & (~shift_r[0] | ten_ok_r)))
      : (shift_r[7:1] == addr_l_r[7:1]);
   assign byte_done = scl_fall & (cnt_r == `I2CS_LAST_BIT);
   // RQ11 software chooses the acknowledge at hold points
   assign ack_low = hit_r & (swack_r ? ~cfg.ack_value_bit : 1'b1);
   // RQ15 update flag stretches without touching the release bit
   assign need_hold = ~ls_r.clock_release_bit | ls_r.update_address_flag;
   // RQ19 grab clock only once low; let go one edge after SDA settles
   assign hold_nxt = (need_hold & (~scl | hold_r)) | (hold_r & (sda_lo_nxt ^ sda_lo_r));

   always_comb begin
      state_nxt = state_r;
      ls_nxt = ls_r;
      cnt_nxt = cnt_r;
      shift_nxt = shift_r;
      txsh_nxt = txsh_r;
      first_nxt = first_r;
      hi_nxt = hi_r;
      lo_nxt = lo_r;
      ten_ok_nxt = ten_ok_r;
      hit_nxt = hit_r;
      swack_nxt = swack_r;
      rx_hold_nxt = rx_hold_r;
      ev_irq = 1'b0;
      ev_bcl = 1'b0;
      ev_load = 1'b0;
      // RQ4 release bit set by software
      if (sw_ev[0]) begin
         ls_nxt.clock_release_bit = 1'b1;
      end
      // RQ15 address register write releases at once
      if (sw_ev[1]) begin
         ls_nxt.update_address_flag = 1'b0;
      end
      if (start_det) begin
         // RQ2 start seen; RQ8 repeated start ends addressing
         ls_nxt.start_seen = 1'b1;
         ls_nxt.stop_seen = 1'b0;
         ev_irq = cfg.start_irq_enable;
         state_nxt = S_RX;
         first_nxt = 1'b1;
         hi_nxt = 1'b0;
         cnt_nxt = `I2CS_CNT_RST;
      end else if (stop_det) begin
         // RQ8 stop ends addressing
         ls_nxt.stop_seen = 1'b1;
         ls_nxt.start_seen = 1'b0;
         state_nxt = S_IDLE;
         ten_ok_nxt = 1'b0;
      end else begin
         case (state_r)
            S_RX: begin
               if (scl_rise) begin
                  shift_nxt = {shift_r[6:0], sda};
                  cnt_nxt = cnt_r + 4'h1;
               end else if (byte_done) begin
                  state_nxt = S_RACK;
                  // RQ10 hold-point cause flags
                  ls_nxt.ack_time_flag = 1'b1;
                  lo_nxt = first_r & cfg.ten_bit_mode & hi_r;
                  hit_nxt = 1'b1;
                  swack_nxt = 1'b0;
                  if (first_r & cfg.ten_bit_mode & hi_r) begin
                     // RQ17 low byte: no load on a miss, release bit untouched
                     hit_nxt = addr_match;
                     ev_load = addr_match;
                     hi_nxt = 1'b0;
                  end else if (first_r) begin
                     if (addr_match) begin
                        ev_load = 1'b1;
                        ls_nxt.read_write = shift_r[0];
                        ls_nxt.data_not_addr = 1'b0;
                        // RQ9 address hold point before the acknowledge
                        if (cfg.address_hold_enable) begin
                           ls_nxt.clock_release_bit = 1'b0;
                           ev_irq = 1'b1;
                           swack_nxt = 1'b1;
                        end
                     end else begin
                        state_nxt = S_IDLE;
                        ls_nxt.ack_time_flag = 1'b0;
                     end
                  end else begin
                     ev_load = 1'b1;
                     ls_nxt.data_not_addr = 1'b1;
                     // RQ22 data hold point
                     if (cfg.data_hold_enable) begin
                        ls_nxt.clock_release_bit = 1'b0;
                        ev_irq = 1'b1;
                        swack_nxt = 1'b1;
                     end
                  end
                  rx_hold_nxt = ev_load ? shift_r : rx_hold_r;
               end
            end
            S_RACK: begin
               if (scl_fall) begin
                  ls_nxt.ack_time_flag = 1'b0;
                  cnt_nxt = `I2CS_CNT_RST;
                  if (lo_r) begin
                     // RQ17 flag and update set whether or not it matched
                     ev_irq = 1'b1;
                     ls_nxt.update_address_flag = 1'b1;
                     ten_ok_nxt = hit_r;
                     first_nxt = 1'b0;
                     state_nxt = hit_r ? S_RX : S_IDLE;
                  end else if (!ack_low) begin
                     // No flag after a software NACK
                     ev_irq = ~swack_r;
                     state_nxt = S_IDLE;
                  end else begin
                     ev_irq = 1'b1;
                     if (first_r & ls_r.read_write) begin
                        // RQ3 read request always clears release bit (RQ21)
                        ls_nxt.clock_release_bit = 1'b0;
                        state_nxt = S_TX;
                     end else if (first_r & cfg.ten_bit_mode & ~ten_ok_r) begin
                        // RQ14 high write byte awaits low address
                        ls_nxt.update_address_flag = 1'b1;
                        hi_nxt = 1'b1;
                        state_nxt = S_RX;
                     end else begin
                        // RQ18 stretch after each received byte (RQ20)
                        if (cfg.stretch_enable) begin
                           ls_nxt.clock_release_bit = 1'b0;
                        end
                        first_nxt = 1'b0;
                        state_nxt = S_RX;
                     end
                  end
               end
            end
            S_TX: begin
               if (cnt_r == `I2CS_CNT_RST && !scl) begin
                  txsh_nxt = tx_r;
               end
               if (scl_rise) begin
                  cnt_nxt = cnt_r + 4'h1;
                  // RQ1 released a one but the line reads low
                  if (txsh_r[7] & ~sda & cfg.slave_collision_detect_enable) begin
                     ev_bcl = 1'b1;
                     state_nxt = S_IDLE;
                  end
               end else if (byte_done) begin
                  state_nxt = S_TACK;
               end else if (scl_fall) begin
                  txsh_nxt = {txsh_r[6:0], 1'b0};
               end
            end
            S_TACK: begin
               if (scl_rise) begin
                  // RQ6 master acknowledge on ninth rising edge
                  ls_nxt.received_ack_status = sda;
               end else if (scl_fall) begin
                  // RQ5 flag after acknowledge capture, on ninth fall (RQ24)
                  ev_irq = 1'b1;
                  cnt_nxt = `I2CS_CNT_RST;
                  // RQ7 ACK stretches again, NACK lets go
                  if (!ls_r.received_ack_status) begin
                     ls_nxt.clock_release_bit = 1'b0;
                     state_nxt = S_TX;
                  end else begin
                     state_nxt = S_IDLE;
                  end
               end
            end
            default: begin
               state_nxt = S_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      case (state_nxt)
         S_RACK: sda_lo_nxt = (state_r == S_RACK) ? ack_low : hit_nxt & ~swack_nxt;
         S_TX: sda_lo_nxt = ~txsh_nxt[7];
         default: sda_lo_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge i_link_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pin_s1_r <= `I2CS_PIN_RST;
         pin_s2_r <= `I2CS_PIN_RST;
         pin_s3_r <= `I2CS_PIN_RST;
         cfg_s1_r <= '0;
         cfg <= '0;
         sw_s1_r <= `I2CS_TGL_RST;
         sw_s2_r <= `I2CS_TGL_RST;
         sw_s3_r <= `I2CS_TGL_RST;
      end else begin
         pin_s1_r <= {i_scl, i_sda};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         cfg_s1_r <= i_cfg;
         cfg <= cfg_s1_r;
         sw_s1_r <= sw_tgl_r;
         sw_s2_r <= sw_s1_r;
         sw_s3_r <= sw_s2_r;
      end
   end

   always_ff @(posedge i_link_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r <= S_IDLE;
         ls_r <= '0;
         ls_r.clock_release_bit <= `I2CS_CKP_RST;
         cnt_r <= `I2CS_CNT_RST;
         shift_r <= `I2CS_BYTE_RST;
         txsh_r <= `I2CS_BYTE_RST;
         rx_hold_r <= `I2CS_BYTE_RST;
         first_r <= 1'b0;
         hi_r <= 1'b0;
         lo_r <= 1'b0;
         ten_ok_r <= 1'b0;
         hit_r <= 1'b0;
         swack_r <= 1'b0;
         sda_lo_r <= 1'b0;
         hold_r <= 1'b0;
         lk_tgl_r <= `I2CS_TGL_RST;
      end else begin
         state_r <= state_nxt;
         ls_r <= ls_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
         txsh_r <= txsh_nxt;
         rx_hold_r <= rx_hold_nxt;
         first_r <= first_nxt;
         hi_r <= hi_nxt;
         lo_r <= lo_nxt;
         ten_ok_r <= ten_ok_nxt;
         hit_r <= hit_nxt;
         swack_r <= swack_nxt;
         sda_lo_r <= sda_lo_nxt;
         hold_r <= hold_nxt;
         lk_tgl_r <= lk_tgl_r ^ {ev_load, ev_bcl, ev_irq};
      end
   end

   // Buffer and address words are stable long before their toggles arrive
   always_ff @(posedge i_link_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tx_r <= `I2CS_BYTE_RST;
         addr_l_r <= `I2CS_BYTE_RST;
      end else begin
         if (sw_ev[2]) begin
            tx_r <= buf_r;
         end
         if (sw_ev[1]) begin
            addr_l_r <= addr_r;
         end
      end
   end

   assign o_scl_out = 1'b0;
   assign o_scl_oe_n = ~hold_r;
   assign o_sda_out = 1'b0;
   assign o_sda_oe_n = ~sda_lo_r;

endmodule : i2cs_slave
